// *** verilog/xpd_defs.svh ***
// Register offsets, reset values and bus constants of the port expander
`ifndef XPD_DEFS_SVH
`define XPD_DEFS_SVH

// Target addresses chosen by the strap pin
`define XPD_TARGET_ADDR_LO  7'h20
`define XPD_TARGET_ADDR_HI  7'h21

// Register indices carried by the command byte
`define XPD_REG_PIN_LEVEL_LO  3'h0
`define XPD_REG_PIN_LEVEL_HI  3'h1
`define XPD_REG_DRIVE_LO      3'h2
`define XPD_REG_DRIVE_HI      3'h3
`define XPD_REG_INVERT_LO     3'h4
`define XPD_REG_INVERT_HI     3'h5
`define XPD_REG_DIR_LO        3'h6
`define XPD_REG_DIR_HI        3'h7

// Register pair field of a register index
`define XPD_PAIR_MSB  2
`define XPD_PAIR_LSB  1

// Reset values, one byte each except the three-bit pointer
`define XPD_RST_DRIVE   8'hff
`define XPD_RST_INVERT  8'h00
`define XPD_RST_DIR     8'hff
`define XPD_RST_PTR     3'h0

// Bits in one serial byte
`define XPD_BITS_PER_BYTE  4'h8

`endif

// *** verilog/xpd_pkg.sv ***
// Types shared by the port expander design
package xpd_pkg;

  typedef enum logic [6:0] {
    XPD_IDLE  = 7'b0000001,
    XPD_ADDR  = 7'b0000010,
    XPD_AACK  = 7'b0000100,
    XPD_RXDAT = 7'b0001000,
    XPD_DACK  = 7'b0010000,
    XPD_TXDAT = 7'b0100000,
    XPD_TACK  = 7'b1000000
  } xpd_state_t;

  typedef struct packed {
    logic [1:0]  sclS;
    logic [1:0]  sdaS;
    logic [1:0]  rstS;
    logic [1:0]  strapS;
    logic [15:0] pinS0;
    logic [15:0] pinS1;
    logic        sclPrev;
    logic        sdaPrev;
    xpd_state_t  state;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic        readXfer;
    logic        firstByte;
    logic [2:0]  ptr;
    logic [2:0]  lastReg;
    logic [15:0] drive;
    logic [15:0] invert;
    logic [15:0] dir;
    logic [15:0] snap;
    logic        primed;
    logic        sdaOe;
    logic        intOe;
    logic [15:0] pinOut;
    logic [15:0] pinOe;
  } xpd_regs_t;

endpackage

// *** verilog/xpd_port_expander.sv ***
// I2C target, register file and pin control of a 16-bit port expander
`timescale 1ns/1ns
`default_nettype none
`include "xpd_defs.svh"

module xpd_port_expander #(
  parameter int NUM_PINS = 16
) (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                rstPinN,
  input  wire logic                addrStrap,
  input  wire logic                sclIn,
  input  wire logic                sdaIn,
  output logic                     sdaOut,
  output logic                     sdaOe,
  output logic                     intOut,
  output logic                     intOe,
  input  wire logic [NUM_PINS-1:0] pinIn,
  output logic      [NUM_PINS-1:0] pinOut,
  output logic      [NUM_PINS-1:0] pinOe
);

  // ==========================================================
  // Elaboration check
  if (NUM_PINS != 16) begin : gBadPins
    $error("xpd_port_expander serves exactly sixteen pins");
  end

  xpd_pkg::xpd_regs_t q;
  xpd_pkg::xpd_regs_t d;

  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic [6:0] myAddr;
  logic       inReset;

  // ==========================================================
  // Register read mux
  function automatic logic [7:0] readReg(
    input xpd_pkg::xpd_regs_t s,
    input logic [2:0]         idx
  );
    logic [15:0] levels;
    logic [7:0]  res;
    levels = s.snap ^ (s.invert & s.dir);
    res    = 8'h00;
    unique case (idx)
      `XPD_REG_PIN_LEVEL_LO: res = levels[7:0];
      `XPD_REG_PIN_LEVEL_HI: res = levels[15:8];
      `XPD_REG_DRIVE_LO:     res = s.drive[7:0];
      `XPD_REG_DRIVE_HI:     res = s.drive[15:8];
      `XPD_REG_INVERT_LO:    res = s.invert[7:0];
      `XPD_REG_INVERT_HI:    res = s.invert[15:8];
      `XPD_REG_DIR_LO:       res = s.dir[7:0];
      `XPD_REG_DIR_HI:       res = s.dir[15:8];
    endcase
    return res;
  endfunction

  // ==========================================================
  // Bus events from synchronised lines
  always_comb begin
    sclRise   = q.sclS[1] & ~q.sclPrev;
    sclFall   = ~q.sclS[1] & q.sclPrev;
    startSeen = q.sclS[1] & q.sclPrev & q.sdaPrev & ~q.sdaS[1];
    stopSeen  = q.sclS[1] & q.sclPrev & ~q.sdaPrev & q.sdaS[1];
    myAddr    = q.strapS[1] ? `XPD_TARGET_ADDR_HI
                            : `XPD_TARGET_ADDR_LO;
    inReset   = ~q.rstS[1];
  end

  // ==========================================================
  // Next state
  always_comb begin
    d = q;

    // Two-flop synchronisers
    d.sclS   = {q.sclS[0], sclIn};
    d.sdaS   = {q.sdaS[0], sdaIn};
    d.rstS   = {q.rstS[0], rstPinN};
    d.strapS = {q.strapS[0], addrStrap};
    d.pinS0  = pinIn;
    d.pinS1  = q.pinS0;
    d.sclPrev = q.sclS[1];
    d.sdaPrev = q.sdaS[1];

    // Input snapshot follows the pins once after reset
    if (!q.primed) begin
      d.snap   = q.pinS1;
      d.primed = 1'b1;
    end

    if (startSeen) begin
      // Repeated start during a read keeps the register in progress
      if (q.readXfer) begin
        d.ptr = q.lastReg;
      end
      d.state    = xpd_pkg::XPD_ADDR;
      d.bitCnt   = 4'h0;
      d.sdaOe    = 1'b0;
      d.readXfer = 1'b0;
    end else if (stopSeen) begin
      d.state    = xpd_pkg::XPD_IDLE;
      d.readXfer = 1'b0;
      d.sdaOe  = 1'b0;
      d.bitCnt = 4'h0;
    end else begin
      unique case (q.state)
        xpd_pkg::XPD_IDLE: begin
          d.sdaOe = 1'b0;
        end

        xpd_pkg::XPD_ADDR: begin
          if (sclRise) begin
            d.shift  = {q.shift[6:0], q.sdaS[1]};
            d.bitCnt = q.bitCnt + 4'h1;
          end else if (sclFall && q.bitCnt == `XPD_BITS_PER_BYTE) begin
            if (q.shift[7:1] == myAddr) begin
              d.sdaOe    = 1'b1;
              d.readXfer = q.shift[0];
              d.state    = xpd_pkg::XPD_AACK;
            end else begin
              d.state = xpd_pkg::XPD_IDLE;
            end
          end
        end

        xpd_pkg::XPD_AACK: begin
          if (sclRise && q.readXfer) begin
            d.snap = q.pinS1;
          end else if (sclFall) begin
            d.bitCnt = 4'h0;
            if (q.readXfer) begin
              // Read uses the stored command, no command byte
              d.shift   = readReg(q, q.ptr);
              d.lastReg = q.ptr;
              d.ptr     = q.ptr ^ 3'h1;
              d.sdaOe   = ~d.shift[7];
              d.bitCnt  = 4'h1;
              d.state   = xpd_pkg::XPD_TXDAT;
            end else begin
              d.sdaOe     = 1'b0;
              d.firstByte = 1'b1;
              d.state     = xpd_pkg::XPD_RXDAT;
            end
          end
        end

        xpd_pkg::XPD_RXDAT: begin
          if (sclRise) begin
            d.shift  = {q.shift[6:0], q.sdaS[1]};
            d.bitCnt = q.bitCnt + 4'h1;
          end else if (sclFall && q.bitCnt == `XPD_BITS_PER_BYTE) begin
            d.sdaOe  = 1'b1;
            d.bitCnt = 4'h0;
            d.state  = xpd_pkg::XPD_DACK;
            if (q.firstByte) begin
              d.ptr       = q.shift[2:0];
              d.firstByte = 1'b0;
            end else begin
              unique case (q.ptr)
                `XPD_REG_DRIVE_LO:  d.drive[7:0]   = q.shift;
                `XPD_REG_DRIVE_HI:  d.drive[15:8]  = q.shift;
                `XPD_REG_INVERT_LO: d.invert[7:0]  = q.shift;
                `XPD_REG_INVERT_HI: d.invert[15:8] = q.shift;
                `XPD_REG_DIR_LO:    d.dir[7:0]     = q.shift;
                `XPD_REG_DIR_HI:    d.dir[15:8]    = q.shift;
                default: d.drive = q.drive;
              endcase
              d.lastReg = q.ptr;
              d.ptr     = q.ptr ^ 3'h1;
            end
          end
        end

        xpd_pkg::XPD_DACK: begin
          if (sclFall) begin
            d.sdaOe = 1'b0;
            d.state = xpd_pkg::XPD_RXDAT;
          end
        end

        xpd_pkg::XPD_TXDAT: begin
          if (sclFall) begin
            if (q.bitCnt == `XPD_BITS_PER_BYTE) begin
              d.sdaOe = 1'b0;
              d.state = xpd_pkg::XPD_TACK;
            end else begin
              d.shift  = {q.shift[6:0], 1'b0};
              d.sdaOe  = ~q.shift[6];
              d.bitCnt = q.bitCnt + 4'h1;
            end
          end
        end

        xpd_pkg::XPD_TACK: begin
          if (sclRise) begin
            // Capture also clears a pending change on input pins
            d.snap = q.pinS1;
            if (q.sdaS[1]) begin
              d.state = xpd_pkg::XPD_IDLE;
            end
          end else if (sclFall) begin
            d.shift   = readReg(q, q.ptr);
            d.lastReg = q.ptr;
            d.ptr     = q.ptr ^ 3'h1;
            d.sdaOe   = ~d.shift[7];
            d.bitCnt  = 4'h1;
            d.state   = xpd_pkg::XPD_TXDAT;
          end
        end

        default: begin
          d.state = xpd_pkg::XPD_IDLE;
          d.sdaOe = 1'b0;
        end
      endcase
    end

    // Pending change on any input-direction pin
    d.intOe = |((q.pinS1 ^ d.snap) & d.dir) & q.primed;

    // Pins follow the registers
    d.pinOut = d.drive;
    d.pinOe  = ~d.dir;

    // Reset pin returns registers and bus engine to defaults
    if (inReset) begin
      d.state     = xpd_pkg::XPD_IDLE;
      d.bitCnt    = 4'h0;
      d.shift     = 8'h00;
      d.readXfer  = 1'b0;
      d.firstByte = 1'b0;
      d.ptr       = `XPD_RST_PTR;
      d.lastReg   = `XPD_RST_PTR;
      d.drive     = {2{`XPD_RST_DRIVE}};
      d.invert    = {2{`XPD_RST_INVERT}};
      d.dir       = {2{`XPD_RST_DIR}};
      d.snap      = 16'h0000;
      d.primed    = 1'b0;
      d.sdaOe     = 1'b0;
      d.intOe     = 1'b0;
      d.pinOut    = {2{`XPD_RST_DRIVE}};
      d.pinOe     = ~{2{`XPD_RST_DIR}};
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q           <= '0;
      q.sclS      <= 2'h3;
      q.sdaS      <= 2'h3;
      q.strapS    <= 2'h0;
      q.sclPrev   <= 1'b1;
      q.sdaPrev   <= 1'b1;
      q.state     <= xpd_pkg::XPD_IDLE;
      q.drive     <= {2{`XPD_RST_DRIVE}};
      q.invert    <= {2{`XPD_RST_INVERT}};
      q.dir       <= {2{`XPD_RST_DIR}};
      q.pinOut    <= {2{`XPD_RST_DRIVE}};
      q.pinOe     <= ~{2{`XPD_RST_DIR}};
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops; open-drain data is always low
  assign sdaOut = q.sdaS[1] & 1'b0;
  assign sdaOe  = q.sdaOe;
  assign intOut = q.sdaS[1] & 1'b0;
  assign intOe  = q.intOe;
  assign pinOut = q.pinOut;
  assign pinOe  = q.pinOe;

endmodule
`default_nettype wire

// *** test/xpd_assertions.sv ***
// Port-level checks of the port expander
`timescale 1ns/1ns
`default_nettype none
module xpd_assertions #(
  parameter int NUM_PINS = 16
) (
  input wire logic                core_clk,
  input wire logic                sys_rst,
  input wire logic                rstPinN,
  input wire logic                addrStrap,
  input wire logic                sclIn,
  input wire logic                sdaIn,
  input wire logic                sdaOut,
  input wire logic                sdaOe,
  input wire logic                intOut,
  input wire logic                intOe,
  input wire logic [NUM_PINS-1:0] pinIn,
  input wire logic [NUM_PINS-1:0] pinOut,
  input wire logic [NUM_PINS-1:0] pinOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  reset_dflt_a:
    assert property ($fell(sys_rst) |-> pinOut == '1 && pinOe == '0)
    else $error("reset defaults wrong");
  pin_reset_a:
    assert property (!rstPinN [*4] |=> pinOut == '1 && pinOe == '0 && !sdaOe)
    else $error("reset pin defaults wrong");
  sda_timing_a:
    assert property ($changed(sdaOe) |-> !sclIn && $past(!sclIn, 2))
    else $error("data line moved near clock high");
  drive_timing_a:
    assert property ($changed(pinOut) && rstPinN && $past(rstPinN, 4)
                     |-> !sclIn)
    else $error("drive level moved with clock high");
  dir_timing_a:
    assert property ($changed(pinOe) && rstPinN && $past(rstPinN, 4)
                     |-> !sclIn)
    else $error("direction moved with clock high");
  open_drain_a:
    assert property (sdaOut == 1'b0 && intOut == 1'b0)
    else $error("open drain level not low");
  stop_idle_a:
    assert property (sclIn && $rose(sdaIn) |=> !sdaOe [*8])
    else $error("data line pulled after stop");
  int_input_a:
    assert property ($rose(intOe) |-> pinOe != '1)
    else $error("interrupt with no input pin");
endmodule
bind xpd_port_expander xpd_assertions #(.NUM_PINS(NUM_PINS)) u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .rstPinN(rstPinN),
  .addrStrap(addrStrap), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .intOut(intOut), .intOe(intOe), .pinIn(pinIn),
  .pinOut(pinOut), .pinOe(pinOe));
`default_nettype wire

// *** test/xpd_i2c_host.sv ***
// Behavioural serial bus controller
`timescale 1ns/1ns
`default_nettype none
module xpd_i2c_host (
  input  wire logic core_clk,
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaPull
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic q();
    repeat (4) @(negedge core_clk);
  endtask
  // Also serves as repeated start
  task automatic start();
    sdaPull = 1'b0;
    q();
    scl = 1'b1;
    q();
    sdaPull = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sdaPull = 1'b1;
    q();
    scl = 1'b1;
    q();
    sdaPull = 1'b0;
    q();
  endtask
  task automatic bit_io(input logic b, output logic s);
    sdaPull = ~b;
    q();
    scl = 1'b1;
    q();
    s = sdaWire;
    scl = 1'b0;
    q();
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], ack);
    end
    bit_io(1'b1, ack);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(nack, s);
  endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench of the port expander
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [15:0] DRV = 16'ha53c;
  localparam logic [15:0] DIR = 16'hf00f;
  localparam logic [15:0] INV = 16'h0f55;
  logic        core_clk;
  logic        sys_rst;
  logic        rstPinN;
  logic        addrStrap;
  logic        sdaOe;
  logic        intOe;
  logic        scl;
  logic        sdaPull;
  logic [15:0] pinDrv;
  logic [15:0] pinOut;
  logic [15:0] pinOe;
  logic [6:0]  devAddr;
  logic        ack;
  logic [7:0]  rd;
  int          err_total;
  int          num_checks;
  wire logic        sdaWire = ~(sdaPull | sdaOe);
  wire logic [15:0] pinWire = (pinOe & pinOut) | (~pinOe & pinDrv);
  xpd_port_expander u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .rstPinN(rstPinN),
    .addrStrap(addrStrap), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(),
    .sdaOe(sdaOe), .intOut(), .intOe(intOe), .pinIn(pinWire),
    .pinOut(pinOut), .pinOe(pinOe));
  xpd_i2c_host u_host (
    .core_clk(core_clk), .sdaWire(sdaWire), .scl(scl), .sdaPull(sdaPull));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  function automatic logic [15:0] exp_in();
    return ((DRV & ~DIR) | (pinDrv & DIR)) ^ (INV & DIR);
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wb(input logic [7:0] b, input logic e);
    u_host.wbyte(b, ack);
    chk("ack", {15'h0, e}, {15'h0, ack});
  endtask
  task automatic rb(input logic nack, input logic [7:0] e);
    u_host.rbyte(nack, rd);
    chk("rdata", {8'h0, e}, {8'h0, rd});
  endtask
  task automatic wr(input logic [7:0] c, d0, d1);
    u_host.start();
    wb({devAddr, 1'b0}, 1'b0);
    wb(c, 1'b0);
    wb(d0, 1'b0);
    wb(d1, 1'b0);
    u_host.stop();
  endtask
  task automatic rdp(input logic cmd, input logic [7:0] c, e0, e1);
    u_host.start();
    if (cmd) begin
      wb({devAddr, 1'b0}, 1'b0);
      wb(c, 1'b0);
      u_host.start();
    end
    wb({devAddr, 1'b1}, 1'b0);
    rb(1'b0, e0);
    rb(1'b1, e1);
    u_host.stop();
  endtask
  initial begin
    sys_rst = 1'b1;
    rstPinN = 1'b1;
    addrStrap = 1'b0;
    pinDrv = 16'h1234;
    devAddr = 7'h20;
    err_total = 0;
    num_checks = 0;
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge core_clk);
    rdp(1'b1, 8'h02, 8'hff, 8'hff);
    rdp(1'b1, 8'h05, 8'h00, 8'h00);
    rdp(1'b1, 8'h07, 8'hff, 8'hff);
    rdp(1'b1, 8'h00, pinDrv[7:0], pinDrv[15:8]);
    wr(8'h03, DRV[15:8], DRV[7:0]);
    wr(8'h06, DIR[7:0], DIR[15:8]);
    wr(8'h05, INV[15:8], INV[7:0]);
    wr(8'h00, 8'h77, 8'h88);
    repeat (10) @(negedge core_clk);
    chk("pinOe", ~DIR, pinOe);
    chk("pinOut", DRV, pinOut);
    rdp(1'b1, 8'h02, DRV[7:0], DRV[15:8]);
    rdp(1'b1, 8'h01, 8'(exp_in() >> 8), 8'(exp_in()));
    pinDrv = pinDrv ^ 16'h0001;
    repeat (10) @(negedge core_clk);
    chk("intOe", 16'h1, {15'h0, intOe});
    rdp(1'b0, 8'h00, 8'(exp_in() >> 8), 8'(exp_in()));
    chk("intOe", 16'h0, {15'h0, intOe});
    u_host.start();
    wb({devAddr, 1'b0}, 1'b0);
    wb(8'h03, 1'b0);
    u_host.start();
    wb({devAddr, 1'b1}, 1'b0);
    rb(1'b1, DRV[15:8]);
    u_host.start();
    wb({devAddr, 1'b1}, 1'b0);
    rb(1'b1, DRV[15:8]);
    u_host.stop();
    addrStrap = 1'b1;
    repeat (10) @(negedge core_clk);
    u_host.start();
    wb({devAddr, 1'b0}, 1'b1);
    u_host.stop();
    devAddr = 7'h21;
    rdp(1'b1, 8'h02, DRV[7:0], DRV[15:8]);
    rstPinN = 1'b0;
    repeat (6) @(negedge core_clk);
    rstPinN = 1'b1;
    repeat (10) @(negedge core_clk);
    chk("pinOe", 16'h0000, pinOe);
    rdp(1'b1, 8'h06, 8'hff, 8'hff);
    stop_test();
  end
  initial begin
    #3000000;
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire
